// ---- verilog/astx_dev.sv ----
// astx_dev: transmit half of the asynchronous serial device with its format latch
// assumes every link input is synchronous to hclk; tx_clock_16x is sampled, not a clock
`include "astx_cfg.svh"
`default_nettype none

// How it works
// - frame order: start, data, parity, stop
// - line idles high between characters
// - falling start edge begins each character
// - host presents byte; low load strobe captures
// - short characters right-justified; upper inputs ignored
// - format bits latched while latch load high
// - host may pulse or tie latch load
// - parity disable stops generation and checking
// - parity error forced low while disabled
// - disabled parity: stop follows last data
// - stop select high two stops, else one
// - five-bit words with stop select: 1.5
// - length selects give 5, 6, 7, 8
// - parity sense shared by transmit and receive
// - sense high even parity, low odd
// - one bit per sixteen 16x clock ticks
// - load rise moves byte now or after frame
// - hold empty rises when byte moves on
// - shift empty high after stops until next
// - master clear empties registers, line high
module astx_dev #(
   parameter int TICKS_PER_BIT = `ASTX_TICKS_PER_BIT
) (
   // clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // link to the host controller
   astx_link_if.dev  link,
   // receive side parity result and frame event
   input  wire logic rx_parity_mismatch,
   output logic      frame_start
);

   localparam int CW = 6;
   localparam logic [CW-1:0] ONE_STOP = CW'(TICKS_PER_BIT);
   localparam logic [CW-1:0] TWO_STOP = CW'(2 * TICKS_PER_BIT);
   localparam logic [CW-1:0] HALF_STOP = CW'(TICKS_PER_BIT + TICKS_PER_BIT / 2);
   localparam logic [CW-1:0] BIT_LAST = CW'(TICKS_PER_BIT - 1);

   if (TICKS_PER_BIT < 2 || TICKS_PER_BIT > 31) begin : g_bad_ticks
      $error("astx_dev: TICKS_PER_BIT must lie in 2..31");
   end

   // state
   astx_pkg::astx_fmt_s        fmt_q;
   astx_pkg::astx_tx_state_e   state_q;
   astx_pkg::astx_tx_state_e   state_d;
   logic [7:0]                 hold_q;
   logic [7:0]                 shift_q;
   logic [7:0]                 shift_d;
   logic [CW-1:0]              cnt_q;
   logic [CW-1:0]              cnt_d;
   logic [2:0]                 bit_q;
   logic [2:0]                 bit_d;
   logic                       tx_q;
   logic                       tx_d;
   logic                       par_q;
   logic                       pend_q;
   logic                       hold_empty_q;
   logic                       shift_empty_q;
   logic                       shift_empty_d;
   logic                       load_n_prev_q;
   logic                       clk16_prev_q;
   logic                       perr_q;
   logic                       start_q;

   // decoded conditions
   wire astx_pkg::astx_fmt_s fmt_in = '{
      even_sel: link.parity_even_sel,
      stop_sel: link.stop_count_sel,
      par_dis:  link.parity_disable,
      len:      {link.char_len_sel_hi, link.char_len_sel_lo}
   };
   wire logic       tick       = link.tx_clock_16x & ~clk16_prev_q;
   wire logic       load_rise  = link.tx_hold_load_n & ~load_n_prev_q;
   wire logic       load_low   = ~link.tx_hold_load_n;
   wire logic [2:0] last_bit   = 3'd4 + {1'b0, fmt_q.len};
   wire logic [7:0] len_mask   = 8'hff >> (3'd3 - {1'b0, fmt_q.len});
   wire logic [7:0] char_data  = hold_q & len_mask;
   wire logic       data_par   = ^char_data;
   wire logic       par_bit    = fmt_q.even_sel ? data_par : ~data_par;
   wire logic [CW-1:0] stop_len =
      !fmt_q.stop_sel   ? ONE_STOP :
      (fmt_q.len == 2'b00) ? HALF_STOP : TWO_STOP;
   wire logic       bit_end    = tick & (cnt_q == BIT_LAST);
   wire logic       stop_end   = (state_q == astx_pkg::ST_STOP) & tick &
                                 (cnt_q == stop_len - CW'(1));
   wire logic       start_now  = pend_q & ((state_q == astx_pkg::ST_IDLE) | stop_end);

   // format latch follows its inputs while the load pin is high; never cleared by master clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fmt_q <= `ASTX_FMT_RST;
      end else if (link.format_latch_load) begin
         fmt_q <= fmt_in;
      end
   end

   // pin edge detectors
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         load_n_prev_q <= 1'b1;
         clk16_prev_q  <= 1'b0;
      end else begin
         load_n_prev_q <= link.tx_hold_load_n;
         clk16_prev_q  <= link.tx_clock_16x;
      end
   end

   // holding register, pending transfer and hold-empty flag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_q       <= 8'h00;
         pend_q       <= 1'b0;
         hold_empty_q <= 1'b1;
      end else if (link.master_clear) begin
         hold_q       <= 8'h00;
         pend_q       <= 1'b0;
         hold_empty_q <= 1'b1;
      end else begin
         if (load_low) begin
            hold_q <= link.tx_parallel_in;
         end
         // a new rising edge wins over the transfer that consumes the old one
         pend_q       <= load_rise | (pend_q & ~start_now);
         // a character being entered wins over the transfer
         hold_empty_q <= ~load_low & (hold_empty_q | start_now);
      end
   end

   // sequencer next state
   always_comb begin
      state_d       = state_q;
      shift_d       = shift_q;
      cnt_d         = tick ? cnt_q + CW'(1) : cnt_q;
      bit_d         = bit_q;
      tx_d          = tx_q;
      shift_empty_d = shift_empty_q;
      unique case (state_q)
         astx_pkg::ST_IDLE: begin
            tx_d          = 1'b1;
            shift_empty_d = 1'b1;
         end
         astx_pkg::ST_START: begin
            if (bit_end) begin
               state_d = astx_pkg::ST_DATA;
               cnt_d   = '0;
               bit_d   = 3'd0;
               tx_d    = shift_q[0];
            end
         end
         astx_pkg::ST_DATA: begin
            if (bit_end) begin
               cnt_d = '0;
               if (bit_q == last_bit) begin
                  if (fmt_q.par_dis) begin
                     state_d = astx_pkg::ST_STOP;
                     tx_d    = 1'b1;
                  end else begin
                     state_d = astx_pkg::ST_PARITY;
                     tx_d    = par_q;
                  end
               end else begin
                  shift_d = shift_q >> 1;
                  tx_d    = shift_q[1];
                  bit_d   = bit_q + 3'd1;
               end
            end
         end
         astx_pkg::ST_PARITY: begin
            if (bit_end) begin
               state_d = astx_pkg::ST_STOP;
               cnt_d   = '0;
               tx_d    = 1'b1;
            end
         end
         astx_pkg::ST_STOP: begin
            if (stop_end) begin
               state_d       = astx_pkg::ST_IDLE;
               cnt_d         = '0;
               shift_empty_d = 1'b1;
            end
         end
         default: begin
            state_d = astx_pkg::ST_IDLE;
            tx_d    = 1'b1;
         end
      endcase
      // a waiting character starts the next frame in the same cycle the last one ends
      if (start_now) begin
         state_d       = astx_pkg::ST_START;
         shift_d       = char_data;
         cnt_d         = '0;
         bit_d         = 3'd0;
         tx_d          = 1'b0;
         shift_empty_d = 1'b0;
      end
   end

   // sequencer registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q       <= astx_pkg::ST_IDLE;
         shift_q       <= 8'h00;
         cnt_q         <= '0;
         bit_q         <= 3'd0;
         tx_q          <= 1'b1;
         shift_empty_q <= 1'b1;
         par_q         <= 1'b0;
         start_q       <= 1'b0;
      end else if (link.master_clear) begin
         state_q       <= astx_pkg::ST_IDLE;
         shift_q       <= 8'h00;
         cnt_q         <= '0;
         bit_q         <= 3'd0;
         tx_q          <= 1'b1;
         shift_empty_q <= 1'b1;
         par_q         <= 1'b0;
         start_q       <= 1'b0;
      end else begin
         state_q       <= state_d;
         shift_q       <= shift_d;
         cnt_q         <= cnt_d;
         bit_q         <= bit_d;
         tx_q          <= tx_d;
         shift_empty_q <= shift_empty_d;
         start_q       <= start_now;
         if (start_now) begin
            par_q <= par_bit;
         end
      end
   end

   // receive parity status, clamped while parity is off
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         perr_q <= 1'b0;
      end else if (link.master_clear) begin
         perr_q <= 1'b0;
      end else begin
         perr_q <= ~fmt_q.par_dis & rx_parity_mismatch;
      end
   end

   // outputs
   assign link.serial_tx_out     = tx_q;
   assign link.tx_hold_empty     = hold_empty_q;
   assign link.tx_shift_empty    = shift_empty_q;
   assign link.parity_error_flag = perr_q;
   assign frame_start            = start_q;

endmodule

`default_nettype wire

// ---- pkg/astx_cfg.svh ----
// astx_cfg.svh: register offsets, field positions, reset values and timing counts
// assumes a 10 MHz hclk; included by bare name after the package
`ifndef ASTX_CFG_SVH
`define ASTX_CFG_SVH

// clock and timing
`define ASTX_CLK_PERIOD_NS   100
`define ASTX_T_STROBE_NS     200
`define ASTX_T_CLEAR_NS      500
`define ASTX_STROBE_CYC      ((`ASTX_T_STROBE_NS + `ASTX_CLK_PERIOD_NS - 1) / `ASTX_CLK_PERIOD_NS)
`define ASTX_CLEAR_CYC       ((`ASTX_T_CLEAR_NS + `ASTX_CLK_PERIOD_NS - 1) / `ASTX_CLK_PERIOD_NS)
`define ASTX_TICKS_PER_BIT   16
`define ASTX_DIV_HALF        1

// controller register offsets (byte addresses)
`define ASTX_REG_FORMAT      8'h00
`define ASTX_REG_TXDATA      8'h04
`define ASTX_REG_STATUS      8'h08
`define ASTX_REG_CONTROL     8'h0c

// format register fields
`define ASTX_FMT_LEN_LSB     0
`define ASTX_FMT_PDIS_BIT    2
`define ASTX_FMT_STOP_BIT    3
`define ASTX_FMT_EVEN_BIT    4
`define ASTX_FMT_FOLLOW_BIT  5

// status register fields
`define ASTX_ST_HOLD_EMPTY   0
`define ASTX_ST_SHIFT_EMPTY  1
`define ASTX_ST_PAR_ERR      2
`define ASTX_ST_LINE         3
`define ASTX_ST_LOAD_BUSY    4

// control register fields
`define ASTX_CTL_CLEAR_BIT   0

// reset values
`define ASTX_FMT_RST         5'h03
`define ASTX_FOLLOW_RST      1'b0

`endif

// ---- pkg/astx_pkg.sv ----
// astx_pkg: types shared by both ends of the serial transmitter link
// assumes nothing of its surroundings
`default_nettype none

package astx_pkg;

   // character format as held in the control latch
   typedef struct packed {
      logic       even_sel;
      logic       stop_sel;
      logic       par_dis;
      logic [1:0] len;
   } astx_fmt_s;

   // transmit sequencer states
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_START  = 3'b001,
      ST_DATA   = 3'b010,
      ST_PARITY = 3'b011,
      ST_STOP   = 3'b100
   } astx_tx_state_e;

endpackage

`default_nettype wire

// ---- pkg/astx_link_if.sv ----
// astx_link_if: pin bundle between the transmitter device and its host controller
// assumes both ends run on the same hclk; all pins are plain one-way levels
`default_nettype none

interface astx_link_if;
   logic       serial_tx_out;
   logic [7:0] tx_parallel_in;
   logic       tx_hold_load_n;
   logic       tx_hold_empty;
   logic       tx_shift_empty;
   logic       format_latch_load;
   logic       parity_disable;
   logic       stop_count_sel;
   logic       char_len_sel_lo;
   logic       char_len_sel_hi;
   logic       parity_even_sel;
   logic       tx_clock_16x;
   logic       parity_error_flag;
   logic       master_clear;

   modport dev (
      output serial_tx_out, tx_hold_empty, tx_shift_empty, parity_error_flag,
      input  tx_parallel_in, tx_hold_load_n, format_latch_load, parity_disable,
      input  stop_count_sel, char_len_sel_lo, char_len_sel_hi, parity_even_sel,
      input  tx_clock_16x, master_clear
   );

   modport host (
      input  serial_tx_out, tx_hold_empty, tx_shift_empty, parity_error_flag,
      output tx_parallel_in, tx_hold_load_n, format_latch_load, parity_disable,
      output stop_count_sel, char_len_sel_lo, char_len_sel_hi, parity_even_sel,
      output tx_clock_16x, master_clear
   );
endinterface

`default_nettype wire

// ---- verilog/astx_host.sv ----
// astx_host: AHB-Lite controlled host that loads characters and format into the device
// assumes a single AHB-Lite master on hclk; its hreadyout is the bus hready
`include "astx_cfg.svh"
`default_nettype none

module astx_host #(
   parameter int DIV_HALF   = `ASTX_DIV_HALF,
   parameter int STROBE_CYC = `ASTX_STROBE_CYC,
   parameter int CLEAR_CYC  = `ASTX_CLEAR_CYC
) (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // link to the device
   astx_link_if.host        link
);

   if (DIV_HALF < 1 || DIV_HALF > 255 || STROBE_CYC < 1 || STROBE_CYC > 15 ||
       CLEAR_CYC < 1 || CLEAR_CYC > 15) begin : g_bad_param
      $error("astx_host: divider or strobe length out of range");
   end

   logic [7:0]          wr_addr_q;
   logic                wr_pend_q;
   logic [31:0]         rdata_q;
   astx_pkg::astx_fmt_s fmt_q;
   logic                follow_q;
   logic [7:0]          data_q;
   logic [3:0]          load_cnt_q;
   logic [3:0]          fmt_cnt_q;
   logic [3:0]          clr_cnt_q;
   logic [7:0]          div_q;
   logic                clk16_q;

   // bus decode
   wire logic       addr_ph   = hsel & htrans[1] & hready;
   wire logic [7:0] a_off     = haddr[7:0];
   wire logic       wr_fmt    = wr_pend_q & (wr_addr_q == `ASTX_REG_FORMAT);
   wire logic       wr_data   = wr_pend_q & (wr_addr_q == `ASTX_REG_TXDATA);
   wire logic       wr_ctl    = wr_pend_q & (wr_addr_q == `ASTX_REG_CONTROL);
   wire logic       load_busy = load_cnt_q != 4'd0;
   wire logic [31:0] status_word = {27'h0, load_busy, link.serial_tx_out,
                                    link.parity_error_flag, link.tx_shift_empty,
                                    link.tx_hold_empty};
   wire logic [31:0] fmt_word    = {26'h0, follow_q, fmt_q};
   wire logic [31:0] rd_word     =
      (a_off == `ASTX_REG_FORMAT) ? fmt_word :
      (a_off == `ASTX_REG_TXDATA) ? {24'h0, data_q} :
      (a_off == `ASTX_REG_STATUS) ? status_word : 32'h0;

   // address phase capture and read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         rdata_q   <= 32'h0;
      end else begin
         wr_pend_q <= addr_ph & hwrite;
         wr_addr_q <= a_off;
         if (addr_ph & ~hwrite) begin
            rdata_q <= rd_word;
         end
      end
   end

   // format register; every write starts a latch pulse, and follow mode ties the latch high
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fmt_q     <= `ASTX_FMT_RST;
         follow_q  <= `ASTX_FOLLOW_RST;
         fmt_cnt_q <= 4'd0;
      end else if (wr_fmt) begin
         fmt_q     <= hwdata[4:0];
         follow_q  <= hwdata[`ASTX_FMT_FOLLOW_BIT];
         fmt_cnt_q <= 4'(STROBE_CYC);
      end else if (fmt_cnt_q != 4'd0) begin
         fmt_cnt_q <= fmt_cnt_q - 4'd1;
      end
   end

   // character load: data and the low strobe start in the same cycle, then the strobe rises
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_q     <= 8'h00;
         load_cnt_q <= 4'd0;
      end else if (wr_data & ~load_busy) begin
         data_q     <= hwdata[7:0];
         load_cnt_q <= 4'(STROBE_CYC);
      end else if (load_busy) begin
         load_cnt_q <= load_cnt_q - 4'd1;
      end
   end

   // master clear pulse
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clr_cnt_q <= 4'd0;
      end else if (wr_ctl & hwdata[`ASTX_CTL_CLEAR_BIT]) begin
         clr_cnt_q <= 4'(CLEAR_CYC);
      end else if (clr_cnt_q != 4'd0) begin
         clr_cnt_q <= clr_cnt_q - 4'd1;
      end
   end

   // 16x bit clock divider
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q   <= 8'h00;
         clk16_q <= 1'b0;
      end else if (div_q == 8'(DIV_HALF - 1)) begin
         div_q   <= 8'h00;
         clk16_q <= ~clk16_q;
      end else begin
         div_q   <= div_q + 8'h01;
      end
   end

   assign hreadyout              = 1'b1;
   assign hresp                  = 1'b0;
   assign hrdata                 = rdata_q;
   assign link.tx_parallel_in    = data_q;
   assign link.tx_hold_load_n    = ~load_busy;
   assign link.format_latch_load = follow_q | (fmt_cnt_q != 4'd0);
   assign link.parity_disable    = fmt_q.par_dis;
   assign link.stop_count_sel    = fmt_q.stop_sel;
   assign link.char_len_sel_lo   = fmt_q.len[0];
   assign link.char_len_sel_hi   = fmt_q.len[1];
   assign link.parity_even_sel   = fmt_q.even_sel;
   assign link.tx_clock_16x      = clk16_q;
   assign link.master_clear      = clr_cnt_q != 4'd0;

endmodule

`default_nettype wire

// ---- verif/astx_link_asserts.sv ----
// astx_link_asserts: timing checks on the pins between device and host
// assumes every pin changes only on rising hclk; instantiated beside the link
`default_nettype none

module astx_link_asserts (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // link pins
   input wire logic serial_tx_out,
   input wire logic tx_hold_load_n,
   input wire logic tx_hold_empty,
   input wire logic tx_shift_empty,
   input wire logic format_latch_load,
   input wire logic parity_disable,
   input wire logic parity_error_flag,
   input wire logic master_clear
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // cycles the line has stayed high, saturating
   logic [7:0] high_run_q;
   logic [7:0] high_run_d;
   assign high_run_d = !serial_tx_out ? 8'h00 : (&high_run_q) ? high_run_q : high_run_q + 8'h01;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         high_run_q <= 8'hff;
      end else begin
         high_run_q <= high_run_d;
      end
   end

   sequence frame_begin;
      $fell(tx_shift_empty);
   endsequence
   sequence start_held;
      !serial_tx_out [*8];
   endsequence

   idle_high_a: assert property (tx_shift_empty |-> serial_tx_out)
      else $error("line low while no frame");
   start_edge_a: assert property (frame_begin |-> $fell(serial_tx_out))
      else $error("frame began without a falling start edge");
   start_bit_a: assert property (disable iff (!hresetn || master_clear)
      frame_begin |-> start_held) else $error("start bit too short");
   load_move_a: assert property (disable iff (!hresetn || master_clear)
      $rose(tx_hold_load_n) && tx_shift_empty |-> ##[1:2] (!tx_shift_empty && tx_hold_empty))
      else $error("idle load did not start a frame");
   hold_full_a: assert property (disable iff (!hresetn || master_clear)
      !tx_hold_load_n |=> !tx_hold_empty) else $error("hold empty high after load");
   stop_run_a: assert property (disable iff (!hresetn || master_clear)
      $rose(tx_shift_empty) && !$past(master_clear) |-> high_run_q >= 8'h1c)
      else $error("shift empty before a full stop bit");
   pe_clamp_a: assert property ((parity_disable && format_latch_load) [*2] |=>
      !parity_error_flag) else $error("parity error while parity disabled");
   clear_idle_a: assert property (master_clear |=>
      serial_tx_out && tx_hold_empty && tx_shift_empty) else $error("clear left link busy");
endmodule

`default_nettype wire

// ---- verif/test_async_serial_transmitter.sv ----
// test_async_serial_transmitter: host and device joined by the link, driven over AHB-Lite
// assumes default counts: one bit is 32 hclk
`include "astx_cfg.svh"
`default_nettype none

module test_async_serial_transmitter;
   timeunit 1ns;
   timeprecision 1ns;

   // format and character in, expected frame bits (lsb first) and frame length out
   typedef struct packed {
      logic [5:0]  fmt;
      logic [7:0]  data;
      logic [3:0]  nbit;
      logic [10:0] bits;
      logic [9:0]  len;
   } astx_row_s;

   logic        hclk;
   logic        hresetn;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   logic        rx_mm;
   logic        frame_start;
   logic [31:0] rd;
   int          n_mismatch;
   int          tests_run;
   int          cyc;
   int          t0;
   astx_row_s   rows [6] = '{
      '{6'h03, 8'ha5, 4'ha, 11'h34a, 10'h160}, '{6'h13, 8'h3c, 4'ha, 11'h078, 10'h160},
      '{6'h08, 8'hff, 4'h7, 11'h03e, 10'h110}, '{6'h0d, 8'hd2, 4'h7, 11'h024, 10'h120},
      '{6'h16, 8'h6b, 4'h8, 11'h0d6, 10'h120}, '{6'h3a, 8'h81, 4'h9, 11'h102, 10'h160}};

   astx_link_if link ();
   astx_dev astx_dev_inst (.hclk(hclk), .hresetn(hresetn), .link(link.dev),
      .rx_parity_mismatch(rx_mm), .frame_start(frame_start));
   astx_host astx_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(link.host));
   astx_link_asserts astx_link_asserts_inst (.hclk(hclk), .hresetn(hresetn),
      .serial_tx_out(link.serial_tx_out), .tx_hold_load_n(link.tx_hold_load_n),
      .tx_hold_empty(link.tx_hold_empty), .tx_shift_empty(link.tx_shift_empty),
      .format_latch_load(link.format_latch_load), .parity_disable(link.parity_disable),
      .parity_error_flag(link.parity_error_flag), .master_clear(link.master_clear));

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      tests_run = tests_run + 1;
      if (s !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, s);
         n_mismatch = n_mismatch + 1;
      end
   endtask

   // start tick phase is loose by up to one 16x period
   task automatic chk_len(input int e, input int el);
      chk("frame length", 32'(e), (el >= e - 4 && el <= e + 1) ? 32'(e) : 32'(el));
   endtask

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask

   task automatic send_char(input astx_row_s r);
      xfer(1'b1, `ASTX_REG_FORMAT, {26'h0, r.fmt});
      xfer(1'b1, `ASTX_REG_TXDATA, {24'h0, r.data});
      while (link.serial_tx_out === 1'b1) @(posedge hclk);
      t0 = cyc;
      chk("frame start", 32'h1, {31'h0, frame_start});
      repeat (16) @(posedge hclk);
      for (int i = 0; i < int'(r.nbit); i++) begin
         chk("frame bit", {31'h0, r.bits[i]}, {31'h0, link.serial_tx_out});
         repeat (32) @(posedge hclk);
      end
      chk("stop bit", 32'h1, {31'h0, link.serial_tx_out});
      while (link.tx_shift_empty !== 1'b1) @(posedge hclk);
      chk_len(int'(r.len), cyc - t0);
   endtask

   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         n_mismatch = n_mismatch + 1;
         give_verdict();
      end
   end

   initial begin
      hresetn = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      rx_mm = 1'b0;
      n_mismatch = 0;
      tests_run = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(1'b0, `ASTX_REG_STATUS, 32'h0);
      chk("status at reset", 32'h0b, rd);
      xfer(1'b0, `ASTX_REG_FORMAT, 32'h0);
      chk("format at reset", 32'h03, rd);
      xfer(1'b1, 8'h10, 32'h5a);
      xfer(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h0, rd);
      foreach (rows[i]) send_char(rows[i]);
      // second load while the first frame runs
      xfer(1'b1, `ASTX_REG_FORMAT, 32'h03);
      xfer(1'b1, `ASTX_REG_TXDATA, 32'h55);
      while (link.tx_hold_empty !== 1'b1 || link.tx_shift_empty !== 1'b0) @(posedge hclk);
      t0 = cyc;
      xfer(1'b1, `ASTX_REG_TXDATA, 32'haa);
      // let the load strobe reach the device before status is sampled
      repeat (4) @(posedge hclk);
      xfer(1'b0, `ASTX_REG_STATUS, 32'h0);
      chk("pending held", 32'h0, rd & 32'h3);
      while (link.tx_shift_empty !== 1'b1) @(posedge hclk);
      chk_len(704, cyc - t0);
      // clear in mid frame
      xfer(1'b1, `ASTX_REG_TXDATA, 32'h0f);
      while (link.serial_tx_out === 1'b1) @(posedge hclk);
      repeat (40) @(posedge hclk);
      xfer(1'b1, `ASTX_REG_CONTROL, 32'h1);
      repeat (8) @(posedge hclk);
      xfer(1'b0, `ASTX_REG_STATUS, 32'h0);
      chk("status after clear", 32'h0b, rd);
      rx_mm <= 1'b1;
      repeat (3) @(posedge hclk);
      xfer(1'b0, `ASTX_REG_STATUS, 32'h0);
      chk("parity error", 32'h1, {31'h0, rd[2]});
      xfer(1'b1, `ASTX_REG_FORMAT, 32'h07);
      repeat (3) @(posedge hclk);
      xfer(1'b0, `ASTX_REG_STATUS, 32'h0);
      chk("parity error off", 32'h0, {31'h0, rd[2]});
      rx_mm <= 1'b0;
      give_verdict();
   end
endmodule

`default_nettype wire
